// ### hdl/adc_serial_consts.svh
`ifndef ADC_SERIAL_CONSTS_SVH
`define ADC_SERIAL_CONSTS_SVH

// sampling interval layout, in master clocks
`define ADC_PERIOD_CLKS 64
`define ADC_PERIODS 16
`define ADC_PHASE_W 10
// self-clocked serial bit length, in master clocks
`define ADC_BIT_CLKS 4
// word-ready high pulse while a new word loads
`define ADC_RDY_PULSE 3'h4
// top bit index of the conversion word
`define ADC_TOP_BIT 4'hf
// uart frame: start, 8 data, 2 stop; last position index
`define ADC_UART_LAST 4'ha
// host wait after sleep, in master clocks
`define ADC_SETTLE_CLKS 507904

`endif

// ### hdl/adc_serial_pkg.sv
package adc_serial_pkg;
  // three-level protocol select pin
  typedef enum logic [1:0] {
    host_clocked_mode,
    self_clocked_mode,
    async_byte_mode
  } mode_t;

  // serial pins as driven by the port
  typedef struct packed {
    logic data;
    logic data_oe;
    logic sclk;
    logic sclk_oe;
  } link_out_t;
endpackage

// ### hdl/adc_serial_output_port.sv
`timescale 1ns/1ns
`include "adc_serial_consts.svh"

module adc_serial_output_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sleep_n,
  input wire adc_serial_pkg::mode_t mode,
  input wire logic chip_sel_n,
  input wire logic sclk_in,
  input wire logic [15:0] conv_word,
  input wire logic conv_valid,
  input wire logic cal_busy,
  output adc_serial_pkg::link_out_t link_o,
  output logic word_ready_n,
  output logic powered_down
);
  logic [2:0] sleep_sync_ff;
  logic [2:0] cs_sync_ff;
  logic [2:0] sclk_sync_ff;
  adc_serial_pkg::mode_t mode_m_ff;
  adc_serial_pkg::mode_t mode_ff;
  logic [`ADC_PHASE_W-1:0] phase_ff;
  logic [15:0] word_ff;
  logic [15:0] pend_ff;
  logic [3:0] bit_ff;
  logic [2:0] hold_ff;
  logic [1:0] sub_ff;
  logic [3:0] upos_ff;
  logic started_ff;
  logic active_ff;
  logic urun_ff;
  logic upper_ff;
  logic ready_n_ff;
  logic pd_ff;
  adc_serial_pkg::link_out_t link_ff;
  logic awake;
  logic cs_low;
  logic sclk_fall;
  logic dig_start;
  logic busy;
  logic is_self;
  logic is_host;
  logic is_async;

  // uart frame bit at a given position, lsb of the byte first
  function automatic logic frame_bit(input logic [15:0] w, input logic up,
                                     input logic [3:0] pos);
    logic [7:0] b;
    b = up ? w[15:8] : w[7:0];
    if (pos == 4'h0) begin
      frame_bit = 1'b0;
    end else if (pos > 4'h8) begin
      frame_bit = 1'b1;
    end else begin
      frame_bit = b[3'(pos - 4'h1)];
    end
  endfunction

  // two-stage synchronisers, third stage for edge finding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_sync_ff <= 3'h0;
      cs_sync_ff <= 3'h7;
      sclk_sync_ff <= 3'h0;
      mode_m_ff <= adc_serial_pkg::host_clocked_mode;
      mode_ff <= adc_serial_pkg::host_clocked_mode;
    end else begin
      sleep_sync_ff <= {sleep_sync_ff[1:0], sleep_n};
      cs_sync_ff <= {cs_sync_ff[1:0], chip_sel_n};
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_in};
      mode_m_ff <= mode;
      mode_ff <= mode_m_ff;
    end
  end

  assign awake = sleep_sync_ff[1];
  assign cs_low = !cs_sync_ff[1];
  assign sclk_fall = sclk_sync_ff[2] && !sclk_sync_ff[1];
  assign is_self = mode_ff == adc_serial_pkg::self_clocked_mode;
  assign is_host = mode_ff == adc_serial_pkg::host_clocked_mode;
  assign is_async = mode_ff == adc_serial_pkg::async_byte_mode;
  // odd periods are digital computation, start at offset zero
  assign dig_start = phase_ff[6] && (phase_ff[5:0] == 6'h0);
  // a running transfer refuses a fresh word
  assign busy = (is_host && cs_low && started_ff)
              || (is_async && cs_low && urun_ff)
              || (is_self && active_ff);

  // sampling interval phase counter, held at zero in sleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= '0;
    end else if (!awake) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + `ADC_PHASE_W'(1);
    end
  end

  // power-down status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_ff <= 1'b0;
    end else begin
      pd_ff <= !awake;
    end
  end

  // word loading, ready flag and serial transfer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_ff <= 16'h0000;
      pend_ff <= 16'h0000;
      bit_ff <= `ADC_TOP_BIT;
      hold_ff <= 3'h0;
      sub_ff <= 2'h0;
      upos_ff <= 4'h0;
      started_ff <= 1'b0;
      active_ff <= 1'b0;
      urun_ff <= 1'b0;
      upper_ff <= 1'b1;
      ready_n_ff <= 1'b1;
      link_ff <= '0;
    end else if (!awake) begin
      // transfer abandoned, word register untouched
      hold_ff <= 3'h0;
      active_ff <= 1'b0;
      urun_ff <= 1'b0;
      ready_n_ff <= 1'b1;
      link_ff <= '0;
    end else if (hold_ff != 3'h0) begin
      // ready held high while the new word settles in
      hold_ff <= hold_ff - 3'h1;
      link_ff <= '0;
      if (hold_ff == 3'h1) begin
        word_ff <= pend_ff;
        bit_ff <= `ADC_TOP_BIT;
        started_ff <= 1'b0;
        upper_ff <= 1'b1;
        ready_n_ff <= cal_busy;
      end
    end else if (cal_busy) begin
      ready_n_ff <= 1'b1;
      link_ff <= '0;
    end else if (conv_valid && !busy) begin
      pend_ff <= conv_word;
      hold_ff <= `ADC_RDY_PULSE;
      ready_n_ff <= 1'b1;
      active_ff <= 1'b0;
      urun_ff <= 1'b0;
      link_ff <= '0;
    end else if (is_self) begin
      if (!active_ff) begin
        if (dig_start && cs_low && !ready_n_ff) begin
          // start or resume at a computation period
          active_ff <= 1'b1;
          started_ff <= 1'b1;
          sub_ff <= 2'h0;
          link_ff <= '{data: word_ff[bit_ff], data_oe: 1'b1,
                       sclk: 1'b0, sclk_oe: 1'b1};
        end else begin
          link_ff <= '0;
        end
      end else begin
        // divided clock: low two cycles, high two cycles
        sub_ff <= sub_ff + 2'h1;
        if (sub_ff == 2'h1 && !cs_low) begin
          // late deselect: float before the clock rises, bit kept
          active_ff <= 1'b0;
          link_ff <= '0;
        end else if (sub_ff == 2'h1) begin
          link_ff.sclk <= 1'b1;
        end else if (sub_ff == 2'h3) begin
          if (bit_ff == 4'h0) begin
            active_ff <= 1'b0;
            ready_n_ff <= 1'b1;
            link_ff <= '0;
          end else if (!cs_low) begin
            bit_ff <= bit_ff - 4'h1;
            active_ff <= 1'b0;
            link_ff <= '0;
          end else begin
            bit_ff <= bit_ff - 4'h1;
            link_ff.sclk <= 1'b0;
            link_ff.data <= word_ff[bit_ff - 4'h1];
          end
        end
      end
    end else if (is_host) begin
      link_ff.sclk <= 1'b0;
      link_ff.sclk_oe <= 1'b0;
      if (!cs_low || ready_n_ff) begin
        link_ff.data_oe <= 1'b0;
      end else if (sclk_fall && started_ff) begin
        if (bit_ff == 4'h0) begin
          ready_n_ff <= 1'b1;
          link_ff.data_oe <= 1'b0;
        end else begin
          bit_ff <= bit_ff - 4'h1;
          link_ff.data <= word_ff[bit_ff - 4'h1];
        end
      end else begin
        // msb valid as soon as chip select falls, same bit on resume
        started_ff <= 1'b1;
        link_ff.data_oe <= 1'b1;
        link_ff.data <= word_ff[bit_ff];
      end
    end else begin
      link_ff.sclk <= 1'b0;
      link_ff.sclk_oe <= 1'b0;
      if (!urun_ff) begin
        link_ff.data_oe <= 1'b0;
        if (sclk_fall && cs_low && !ready_n_ff) begin
          urun_ff <= 1'b1;
          upos_ff <= 4'h0;
          link_ff.data <= 1'b0;
          link_ff.data_oe <= 1'b1;
        end
      end else if (sclk_fall) begin
        if (upos_ff == `ADC_UART_LAST) begin
          urun_ff <= 1'b0;
          link_ff.data_oe <= 1'b0;
          upper_ff <= 1'b0;
          ready_n_ff <= !upper_ff;
        end else begin
          upos_ff <= upos_ff + 4'h1;
          link_ff.data <= frame_bit(word_ff, upper_ff, upos_ff + 4'h1);
        end
      end
    end
  end

  assign link_o = link_ff;
  assign word_ready_n = ready_n_ff;
  assign powered_down = pd_ff;

  chk_sleep_float: assert property (@(posedge clk) disable iff (!rstn)
    !awake |=> !link_ff.data_oe && !link_ff.sclk_oe)
    else $error("outputs driven during sleep");
  chk_self_sclk_drive: assert property (@(posedge clk) disable iff (!rstn)
    $rose(active_ff) |-> link_ff.sclk_oe && link_ff.data_oe)
    else $error("self-clocked start without driven clock");
  chk_self_start_slot: assert property (@(posedge clk) disable iff (!rstn)
    $rose(active_ff) |-> $past(phase_ff[6:0]) == 7'h40)
    else $error("self-clocked send began outside period start");
  chk_done_float: assert property (@(posedge clk) disable iff (!rstn)
    ready_n_ff |-> !link_ff.data_oe)
    else $error("data driven while word ready is high");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (hold_ff == `ADC_RDY_PULSE) |-> ready_n_ff [*4] ##1
      (!ready_n_ff || $past(cal_busy)))
    else $error("word ready pulse not four clocks");
  chk_self_edges: assert property (@(posedge clk) disable iff (!rstn)
    (active_ff && $past(active_ff) && $changed(link_ff.data))
      |-> $fell(link_ff.sclk))
    else $error("self-clocked data changed off falling edge");
  chk_host_cs_float: assert property (@(posedge clk) disable iff (!rstn)
    (is_host && !cs_low) |=> !link_ff.data_oe)
    else $error("host mode data driven with chip select high");
  chk_host_keep_word: assert property (@(posedge clk) disable iff (!rstn)
    (is_host && cs_low && started_ff && conv_valid) |=> hold_ff == 3'h0)
    else $error("host mode word replaced mid transfer");
  chk_async_keep_word: assert property (@(posedge clk) disable iff (!rstn)
    (is_async && cs_low && urun_ff && conv_valid) |=> $stable(word_ff))
    else $error("async word replaced mid byte");
  chk_cal_ready: assert property (@(posedge clk) disable iff (!rstn)
    (cal_busy && awake) |=> ready_n_ff)
    else $error("word ready low during calibration");
endmodule

// ### tb/adc_host_model.sv
`timescale 1ns/1ns
// far-side host: drives chip select and a 160 ns serial clock
module adc_host_model (
  input wire logic clk,
  input wire adc_serial_pkg::link_out_t link_o,
  output logic chip_sel_n,
  output logic sclk_in
);
  logic last_ff;
  logic pin;
  // a released data pin reads back inverted, never a stale level
  always_ff @(posedge clk) begin
    if (link_o.data_oe) begin
      last_ff <= link_o.data;
    end
  end
  assign pin = link_o.data_oe ? link_o.data : ~last_ff;
  initial begin
    chip_sel_n = 1'b1;
    sclk_in = 1'b1;
  end
  // one baud cycle from the master clock; idle high between frames
  task automatic baud();
    sclk_in = 1'b0;
    repeat (4) @(negedge clk);
    sclk_in = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // synchronous read, msb first; fl set when pins float after deselect
  task automatic sync_read(input int n, input logic slf,
                           output logic [15:0] w, output logic fl,
                           output logic to);
    int k;
    logic p;
    w = 16'h0;
    to = 1'b0;
    chip_sel_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      if (slf) begin
        k = 0;
        p = 1'b1;
        // capture on the rising generated clock
        while (k < 1200 && !(link_o.sclk_oe && link_o.sclk && !p)) begin
          p = link_o.sclk;
          @(negedge clk);
          k++;
        end
        to = to | (k == 1200);
        w = {w[14:0], pin};
      end else begin
        w = {w[14:0], pin};
        baud();
      end
    end
    chip_sel_n = 1'b1;
    repeat (5) @(negedge clk);
    fl = !(link_o.data_oe || link_o.sclk_oe);
  endtask
  // one uart frame: start, eight bits lsb first, two stop bits
  task automatic async_frame(output logic [10:0] f, output logic fl);
    chip_sel_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      baud();
      f = {pin, f[10:1]};
    end
    baud();
    fl = !link_o.data_oe;
    chip_sel_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ### tb/adc_serial_output_port_tb_top.sv
`timescale 1ns/1ns
module adc_serial_output_port_tb_top;
  typedef struct packed {
    adc_serial_pkg::mode_t m;
    logic [15:0] w;
    logic [15:0] exp;
  } row_t;
  logic clk, rstn, sleep_n, chip_sel_n, sclk_in, conv_valid, cal_busy;
  logic word_ready_n, powered_down, fl, to;
  logic [15:0] conv_word, got;
  logic [10:0] f1, f2;
  adc_serial_pkg::mode_t mode;
  adc_serial_pkg::link_out_t link_o;
  int n_fail = 0;
  int tests_run = 0;
  row_t rows [5] = '{
    '{adc_serial_pkg::host_clocked_mode, 16'ha5c3, 16'ha5c3},
    '{adc_serial_pkg::self_clocked_mode, 16'h8001, 16'h8001},
    '{adc_serial_pkg::async_byte_mode, 16'h7e18, 16'h7e18},
    '{adc_serial_pkg::host_clocked_mode, 16'hffff, 16'hffff},
    '{adc_serial_pkg::async_byte_mode, 16'h0100, 16'h0100}};

  adc_serial_output_port u_adc_serial_output_port (.clk(clk), .rstn(rstn),
    .sleep_n(sleep_n), .mode(mode), .chip_sel_n(chip_sel_n),
    .sclk_in(sclk_in), .conv_word(conv_word), .conv_valid(conv_valid),
    .cal_busy(cal_busy), .link_o(link_o), .word_ready_n(word_ready_n),
    .powered_down(powered_down));
  adc_host_model u_adc_host_model (.clk(clk), .link_o(link_o),
    .chip_sel_n(chip_sel_n), .sclk_in(sclk_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic bound(input logic t);
    if (t) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic offer(input logic [15:0] w);
    conv_word = w;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
  endtask
  // load a word and time its ready pulse
  task automatic load(input logic [15:0] w);
    int n;
    offer(w);
    n = 0;
    while (word_ready_n === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    check("pulse", 16'(n), 16'h4);
    bound(n == 20);
  endtask
  task automatic set_mode(input adc_serial_pkg::mode_t m);
    mode = m;
    repeat (4) @(negedge clk);
  endtask
  task automatic get_word(output logic [15:0] w);
    if (mode == adc_serial_pkg::async_byte_mode) begin
      u_adc_host_model.async_frame(f1, fl);
      u_adc_host_model.async_frame(f2, fl);
      check("frame", {10'h0, f1[10:9], f1[0], f2[10:9], f2[0]}, 16'h36);
      w = {f1[8:1], f2[8:1]};
    end else begin
      u_adc_host_model.sync_read(16,
        mode == adc_serial_pkg::self_clocked_mode, w, fl, to);
      bound(to);
    end
  endtask

  initial begin
    rstn = 1'b0;
    sleep_n = 1'b1;
    mode = adc_serial_pkg::host_clocked_mode;
    conv_word = 16'h0;
    conv_valid = 1'b0;
    cal_busy = 1'b0;
    repeat (16) @(negedge clk);
    check("rst", {word_ready_n, powered_down, 10'h0, link_o}, 16'h8000);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    // ordinary transfers: two host-clocked, one self-clocked, two async
    for (int r = 0; r < 5; r++) begin
      set_mode(rows[r].m);
      load(rows[r].w);
      get_word(got);
      check("word", got, rows[r].exp);
      check("float", {15'h0, fl}, 16'h1);
      check("ready_n", {15'h0, word_ready_n}, 16'h1);
    end
    // unread word replaced while deselected
    set_mode(adc_serial_pkg::host_clocked_mode);
    load(16'h1234);
    load(16'hbeef);
    get_word(got);
    check("replace", got, 16'hbeef);
    // deselect mid-word, then resume from the same bit
    load(16'hc3a5);
    u_adc_host_model.sync_read(8, 1'b0, got, fl, to);
    check("part", got, 16'h00c3);
    check("part_fl", {15'h0, fl}, 16'h1);
    u_adc_host_model.sync_read(8, 1'b0, got, fl, to);
    check("resume", got, 16'h00a5);
    // new word during a running transfer is dropped
    load(16'h5a5a);
    fork
      get_word(got);
      begin
        repeat (60) @(negedge clk);
        offer(16'h0f0f);
      end
    join
    check("keep", got, 16'h5a5a);
    // async: word offered mid-byte is ignored; no load between bytes
    set_mode(adc_serial_pkg::async_byte_mode);
    load(16'h9c63);
    fork
      u_adc_host_model.async_frame(f1, fl);
      begin
        repeat (40) @(negedge clk);
        offer(16'h0000);
      end
    join
    u_adc_host_model.async_frame(f2, fl);
    check("async_keep", {f1[8:1], f2[8:1]}, 16'h9c63);
    // self-clocked: deselect after eight bits, resume at a later period
    set_mode(adc_serial_pkg::self_clocked_mode);
    load(16'hc35a);
    u_adc_host_model.sync_read(8, 1'b1, got, fl, to);
    bound(to);
    check("self_part", got, 16'h00c3);
    check("self_fl", {15'h0, fl}, 16'h1);
    u_adc_host_model.sync_read(8, 1'b1, got, fl, to);
    bound(to);
    check("self_resume", got, 16'h005a);
    // calibration holds ready high
    load(16'h4242);
    cal_busy = 1'b1;
    repeat (6) @(negedge clk);
    check("cal", {15'h0, word_ready_n}, 16'h1);
    cal_busy = 1'b0;
    // sleep shuts the port down
    sleep_n = 1'b0;
    repeat (5) @(negedge clk);
    check("sleep", {14'h0, powered_down, link_o.data_oe}, 16'h2);
    // only powered_down is read after wake: settling outlasts the run
    sleep_n = 1'b1;
    repeat (5) @(negedge clk);
    check("wake", {15'h0, powered_down}, 16'h0);
    tally_and_finish();
  end
endmodule
